/* logic/asq_top.sv */
`timescale 1ns/1ps
// Purpose: Sequencer, control registers and bus answer of the converter.
// Assumes: Byte registers at even addresses, data on bus lanes 15:8.
// Notes: Read data appears one cycle after bus_rd.
module asq_top import asq_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic standby,
    input wire logic [7:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic bus_dma,
    input wire logic [7:0] bus_wdata,
    output logic [15:0] bus_rdata,
    input wire logic ext_trigger_pin,
    output logic conv_end_irq,
    output logic core_start,
    output logic [2:0] core_chan,
    output logic core_speed,
    input wire logic core_done,
    input wire logic [9:0] core_result
);
    typedef struct packed {
        logic conv_end_flag;
        logic conv_end_irq_enable;
        logic conv_start_bit;
        logic multi;
        logic conv_speed_select;
        logic [2:0] chan_sel;
        logic ext_trig_en_hi;
        logic ext_trig_en_lo;
        logic continuous_select;
        logic flag_armed;
        asq_state_t st;
        logic [15:0] rdata;
        logic irq;
        logic core_start;
        logic [2:0] core_chan;
        logic core_speed;
    } asq_seq_t;

    asq_seq_t s, next_s;
    asq_res_if rif ();
    logic trig_fall;
    logic wr_csr, wr_tcr, rd_res, set_flag, clr_flag, start_req, stop_req, done_ok;
    logic last_chan;

    asq_trig_sync u_trig (
        .clk(clk),
        .rst(rst),
        .pin(ext_trigger_pin),
        .fall(trig_fall)
    );

    asq_result_bank u_bank (
        .clk(clk),
        .rb(rif.bank)
    );

    function automatic logic [7:0] csr_byte(input asq_seq_t v);
        csr_byte = {v.conv_end_flag, v.conv_end_irq_enable, v.conv_start_bit,
            v.multi, v.conv_speed_select, v.chan_sel};
    endfunction

    function automatic logic [7:0] tcr_byte(input asq_seq_t v);
        // Reserved pair reads zero, low three read one
        tcr_byte = {v.ext_trig_en_hi, v.ext_trig_en_lo, v.continuous_select,
            2'h0, TCR_ONES};
    endfunction

    function automatic logic [2:0] first_chan(input asq_seq_t v);
        first_chan = v.multi ? {v.chan_sel[2], 2'h0} : v.chan_sel;
    endfunction

    always_comb begin
        next_s = s;
        next_s.core_start = 1'b0;
        next_s.rdata = 16'h0000;
        set_flag = 1'b0;
        clr_flag = 1'b0;
        done_ok = 1'b0;
        wr_csr = bus_wr && (bus_addr == OFF_CSR);
        wr_tcr = bus_wr && (bus_addr == OFF_TCR);
        rd_res = bus_rd && (bus_addr >= OFF_RES_A) && (bus_addr <= OFF_RES_LAST);
        rif.wr = 1'b0;
        rif.wsel = s.core_chan[1:0];
        rif.wdata = core_result;
        rif.clr = 1'b0;
        rif.rd_hi = rd_res && !bus_addr[1];
        rif.rd_lo = rd_res && bus_addr[1];
        rif.rsel = bus_addr[3:2];
        last_chan = !s.multi || (s.core_chan[1:0] == s.chan_sel[1:0]);

        // Register reads, all on the upper lanes
        if (bus_rd) begin
            if (bus_addr == OFF_CSR) begin
                next_s.rdata = {csr_byte(s), 8'h00};
                if (s.conv_end_flag) begin
                    next_s.flag_armed = 1'b1;
                end
            end else if (bus_addr == OFF_TCR) begin
                next_s.rdata = {tcr_byte(s), 8'h00};
            end else if (rd_res) begin
                next_s.rdata = {rif.rbyte, 8'h00};
                if (bus_dma) begin
                    clr_flag = 1'b1;
                end
            end
        end

        // Register writes
        if (wr_csr) begin
            next_s.conv_end_irq_enable = bus_wdata[BIT_IE];
            next_s.multi = bus_wdata[BIT_MODE];
            next_s.conv_speed_select = bus_wdata[BIT_SPEED];
            next_s.chan_sel = bus_wdata[2:0];
            // Writing 1 to the flag is ignored; 0 only counts after a read of 1
            if (!bus_wdata[BIT_END] && s.flag_armed) begin
                clr_flag = 1'b1;
            end
            next_s.flag_armed = 1'b0;
        end
        if (wr_tcr) begin
            next_s.ext_trig_en_hi = bus_wdata[BIT_TEN_HI];
            next_s.ext_trig_en_lo = bus_wdata[BIT_TEN_LO];
            next_s.continuous_select = bus_wdata[BIT_SCAN];
        end

        start_req = (wr_csr && bus_wdata[BIT_START])
            || (trig_fall && s.ext_trig_en_hi && s.ext_trig_en_lo);
        stop_req = wr_csr && !bus_wdata[BIT_START] && !start_req;

        case (s.st)
            ASQ_IDLE: begin
                if (start_req) begin
                    next_s.conv_start_bit = 1'b1;
                    next_s.core_start = 1'b1;
                    next_s.core_chan = first_chan(next_s);
                    next_s.st = ASQ_WAIT;
                end
            end
            ASQ_WAIT: begin
                if (stop_req) begin
                    // Abandon now; a done in this cycle is dropped
                    next_s.conv_start_bit = 1'b0;
                    next_s.st = ASQ_IDLE;
                end else if (core_done) begin
                    done_ok = 1'b1;
                    rif.wr = 1'b1;
                    if (last_chan) begin
                        set_flag = 1'b1;
                    end
                    if (last_chan && !(s.multi && s.continuous_select)) begin
                        next_s.conv_start_bit = 1'b0;
                        next_s.st = ASQ_IDLE;
                    end else begin
                        next_s.core_start = 1'b1;
                        next_s.core_chan = last_chan ? first_chan(s)
                            : s.core_chan + 3'h1;
                    end
                end
            end
            default: begin
                next_s.st = ASQ_IDLE;
                next_s.conv_start_bit = 1'b0;
            end
        endcase

        // Hardware set wins over a write or DMA clear in the same cycle; reset and standby win over it
        if (set_flag) begin
            next_s.conv_end_flag = 1'b1;
        end else if (clr_flag) begin
            next_s.conv_end_flag = 1'b0;
        end
        next_s.core_speed = next_s.conv_speed_select;

        if (rst || standby) begin
            next_s = '0;
            next_s.st = ASQ_IDLE;
            {next_s.ext_trig_en_hi, next_s.ext_trig_en_lo, next_s.continuous_select}
                = TCR_RESET[7:5];
            rif.clr = 1'b1;
            rif.wr = 1'b0;
        end
        next_s.irq = next_s.conv_end_flag && next_s.conv_end_irq_enable;
    end

    always_ff @(posedge clk) begin
        s <= next_s;
    end

    assign bus_rdata = s.rdata;
    assign conv_end_irq = s.irq;
    assign core_start = s.core_start;
    assign core_chan = s.core_chan;
    assign core_speed = s.core_speed;

    default clocking @(posedge clk);
    endclocking
    default disable iff (rst || standby);

    a_csr_reset: assert property (@(posedge clk) disable iff (1'b0)
        (rst || standby) |=> csr_byte(s) == CSR_RESET
        && tcr_byte(s) == TCR_RESET)
        else $error("Registers not reset");
    a_flag_single: assert property (s.st == ASQ_WAIT && core_done && !s.multi
        && !stop_req |=> s.conv_end_flag && !s.conv_start_bit && s.st == ASQ_IDLE)
        else $error("Single end missed");
    a_flag_write_one: assert property (wr_csr && bus_wdata[BIT_END] && s.conv_end_flag
        && !(bus_rd && bus_dma) |=> s.conv_end_flag)
        else $error("Writing 1 cleared flag");
    a_flag_needs_read: assert property (wr_csr && !s.flag_armed && s.conv_end_flag
        && !rd_res |=> s.conv_end_flag)
        else $error("Flag cleared without prior read");
    a_irq_gate: assert property (##1 conv_end_irq == ($past(next_s.conv_end_flag)
        && $past(next_s.conv_end_irq_enable)) && (conv_end_irq ->
        s.conv_end_flag && s.conv_end_irq_enable))
        else $error("Interrupt not gated by enable");
    a_scan_keeps: assert property (s.st == ASQ_WAIT && core_done && !stop_req
        && s.multi && s.continuous_select |=> s.conv_start_bit && core_start)
        else $error("Scan stopped on its own");
    a_trig_gate: assert property (s.st == ASQ_IDLE && trig_fall && !bus_wr
        |=> s.conv_start_bit == $past(s.ext_trig_en_hi && s.ext_trig_en_lo))
        else $error("Trigger gating wrong");
    a_group_first: assert property (s.st == ASQ_IDLE && start_req && next_s.multi
        |=> core_start && core_chan[1:0] == 2'h0)
        else $error("Group did not start at first channel");
    a_abandon_quiet: assert property (s.st == ASQ_WAIT && stop_req
        |=> s.st == ASQ_IDLE && !s.conv_start_bit
        && s.conv_end_flag == $past(s.conv_end_flag && !clr_flag))
        else $error("Abandon touched flag");
    a_multi_step: assert property (s.st == ASQ_WAIT && core_done && !stop_req && !last_chan
        |=> core_start && core_chan == $past(s.core_chan) + 3'h1 && !s.conv_end_flag
        || $past(s.conv_end_flag))
        else $error("Next channel not started");

    // Flag and interrupt
    a_dma_clear: assert property (rd_res && bus_dma && !set_flag
        |=> !s.conv_end_flag)
        else $error("DMA read left flag set");
    a_armed_clear: assert property (wr_csr && !bus_wdata[BIT_END] && s.flag_armed
        && !set_flag |=> !s.conv_end_flag)
        else $error("Armed clear ignored");
    a_set_wins: assert property (set_flag
        |=> s.conv_end_flag)
        else $error("Flag set lost");
    a_multi_end: assert property (s.st == ASQ_WAIT && core_done && !stop_req && last_chan
        && s.multi && !s.continuous_select |=> s.conv_end_flag && !s.conv_start_bit)
        else $error("Multi pass end missed");
    a_idle_done: assert property (s.st == ASQ_IDLE && core_done && !bus_wr && !bus_rd
        |=> s.conv_end_flag == $past(s.conv_end_flag))
        else $error("Idle done moved flag");
    a_irq_off: assert property (!s.conv_end_irq_enable
        |-> !conv_end_irq)
        else $error("Request raised while disabled");
    a_ie_write: assert property (wr_csr
        |=> s.conv_end_irq_enable == $past(bus_wdata[BIT_IE]))
        else $error("Enable bit not written");
    // Sequencing and core strobes
    a_busy_bit: assert property (s.conv_start_bit
        == (s.st == ASQ_WAIT))
        else $error("Start bit disagrees with state");
    a_single_chan: assert property (s.st == ASQ_IDLE && start_req && !next_s.multi
        |=> core_start && core_chan == $past(next_s.chan_sel))
        else $error("Single channel wrong");
    a_scan_wrap: assert property (s.st == ASQ_WAIT && core_done && !stop_req && last_chan
        && s.multi && s.continuous_select |=> core_chan == {$past(s.chan_sel[2]), 2'h0})
        else $error("Scan did not wrap to first channel");
    a_result_write: assert property (s.st == ASQ_WAIT && core_done && !stop_req
        |-> rif.wr && rif.wsel == s.core_chan[1:0])
        else $error("Result not routed");
    a_abandon_no_write: assert property (stop_req
        |-> !rif.wr)
        else $error("Abandoned result written");
    a_stop_no_start: assert property (s.st == ASQ_WAIT && stop_req
        |=> !core_start)
        else $error("Start after abandon");
    a_speed_copy: assert property (wr_csr
        |=> core_speed == $past(bus_wdata[BIT_SPEED]))
        else $error("Speed not passed to core");
    a_scan_write: assert property (wr_tcr
        |=> s.continuous_select == $past(bus_wdata[BIT_SCAN]))
        else $error("Scan bit not written");
    // Bus answer
    a_trig_fixed_bits: assert property (bus_rd && bus_addr == OFF_TCR
        |=> bus_rdata[10:8] == TCR_ONES && bus_rdata[12:11] == 2'h0)
        else $error("Fixed trigger bits wrong");
    a_rdata_idle: assert property (!bus_rd
        |=> bus_rdata == 16'h0000)
        else $error("Read data outside answer");
    a_rdata_low: assert property (bus_rdata[7:0]
        == 8'h00)
        else $error("Low lanes driven");
    a_lower_zero: assert property (rif.rd_lo
        |=> bus_rdata[13:8] == 6'h00)
        else $error("Low byte spare bits set");

    c_single_done: cover property (s.st == ASQ_WAIT && core_done && !s.multi);
    c_multi_pass: cover property (s.st == ASQ_WAIT && core_done && last_chan
        && s.multi && !s.continuous_select);
    c_scan_wrap: cover property (s.st == ASQ_WAIT && core_done && last_chan
        && s.multi && s.continuous_select);
    c_trig_start: cover property (s.st == ASQ_IDLE && trig_fall
        && s.ext_trig_en_hi && s.ext_trig_en_lo);
    c_dma_clear: cover property (rd_res && bus_dma && s.conv_end_flag);
endmodule // asq_top

/* logic/asq_pkg.sv */
// Purpose: Shared constants and types of the converter sequencer.
// Assumes: Low address byte of the peripheral bus; data on lanes 15:8.
// Notes: Conversion time is owned by the analog core; figures are in clk cycles.
//
// How it works
// - Control/status register is eight bits, zero after reset and in standby.
// - End flag clears by writing 0 after reading it as 1.
// - A DMA read of a result register also clears the end flag.
// - End flag sets after single conversion, or after the last channel of a pass.
// - Interrupt request is end flag AND interrupt enable bit 6.
// - Start bit reads 1 while converting; auto clears in single and multi.
// - Scan mode cycles until start is cleared, reset or standby.
// - Mode bit 0 gives single; else scan bit picks multi or scan.
// - Speed select bit 3 picks 536 or 266 state conversion maximum.
// - Single picks one channel; group modes pick group and channel count.
// - Trigger control register resets to 0x07 on reset and standby.
// - Falling trigger edge starts conversion only with both enables set.
// - Qualified trigger edge sets the start bit like a software write.
// - Trigger bits 4,3 read 0, bits 2..0 read 1; writes ignored there.
// - Result registers use upper bus lanes; low byte goes through a latch.
// - Upper byte read returns it and copies the low byte to the latch.
// - Result bits 9..2 in upper byte, bits 1..0 at low byte bits 7..6.
// - Channels n and n+4 share result register n.
// - Result registers clear on reset and standby.
// - Group modes start at the group's first channel and step at once.
package asq_pkg;
    localparam logic [7:0] OFF_RES_A = 8'h80;
    localparam logic [7:0] OFF_RES_LAST = 8'h8e;
    localparam logic [7:0] OFF_CSR = 8'h90;
    localparam logic [7:0] OFF_TCR = 8'h92;
    localparam int BIT_END = 7;
    localparam int BIT_IE = 6;
    localparam int BIT_START = 5;
    localparam int BIT_MODE = 4;
    localparam int BIT_SPEED = 3;
    localparam int BIT_TEN_HI = 7;
    localparam int BIT_TEN_LO = 6;
    localparam int BIT_SCAN = 5;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [7:0] TCR_RESET = 8'h07;
    localparam logic [2:0] TCR_ONES = 3'h7;
    localparam int CONV_MAX_SLOW = 536;
    localparam int CONV_MAX_FAST = 266;
    localparam int CLK_PERIOD_NS = 25;

    typedef enum logic [1:0] {
        ASQ_IDLE = 2'h0,
        ASQ_WAIT = 2'h1
    } asq_state_t;
endpackage

/* logic/asq_res_if.sv */
`timescale 1ns/1ps
// Purpose: Link between sequencer and result bank.
// Assumes: Single clock; rbyte is combinational from the bank.
// Notes: None.
interface asq_res_if;
    logic wr;
    logic [1:0] wsel;
    logic [9:0] wdata;
    logic clr;
    logic rd_hi;
    logic rd_lo;
    logic [1:0] rsel;
    logic [7:0] rbyte;
    modport seq (output wr, wsel, wdata, clr, rd_hi, rd_lo, rsel, input rbyte);
    modport bank (input wr, wsel, wdata, clr, rd_hi, rd_lo, rsel, output rbyte);
endinterface

/* logic/asq_trig_sync.sv */
`timescale 1ns/1ps
// Purpose: Synchronise the trigger pin and flag its falling edges.
// Assumes: Pin idles high.
// Notes: A change counts only when stages two and three agree.
module asq_trig_sync import asq_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic fall;
    } asq_sync_t;
    asq_sync_t s, next_s;

    always_comb begin
        next_s = s;
        next_s.s1 = pin;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.fall = 1'b0;
        if (s.s2 == s.s3) begin
            next_s.level = s.s3;
            next_s.fall = s.level && !s.s3;
        end
        if (rst) begin
            next_s = '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1, fall: 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        s <= next_s;
    end

    assign fall = s.fall;
endmodule // asq_trig_sync

/* logic/asq_result_bank.sv */
`timescale 1ns/1ps
// Purpose: Four result registers and the low-byte holding latch.
// Assumes: Reads and writes are steered by the sequencer.
// Notes: rbyte is combinational; the top registers it.
module asq_result_bank import asq_pkg::*; (
    input wire logic clk,
    asq_res_if.bank rb
);
    typedef struct packed {
        logic [3:0][9:0] regs;
        logic [7:0] latch;
    } asq_bank_t;
    asq_bank_t s, next_s;

    always_comb begin
        next_s = s;
        if (rb.wr) begin
            next_s.regs[rb.wsel] = rb.wdata;
        end
        if (rb.rd_hi) begin
            next_s.latch = {s.regs[rb.rsel][1:0], 6'h00};
        end
        if (rb.clr) begin
            next_s = '0;
        end
    end

    always_ff @(posedge clk) begin
        s <= next_s;
    end

    // Lower byte comes only from the latch, never the register itself
    assign rb.rbyte = rb.rd_hi ? s.regs[rb.rsel][9:2] : s.latch;

    a_result_route: assert property (@(posedge clk) rb.wr && !rb.clr
        |=> s.regs[$past(rb.wsel)] == $past(rb.wdata))
        else $error("Result not stored in mapped register");
    a_latch_copy: assert property (@(posedge clk) rb.rd_hi && !rb.wr && !rb.clr
        |=> s.latch == {s.regs[$past(rb.rsel)][1:0], 6'h00})
        else $error("Latch missed low byte");
    a_bank_clear: assert property (@(posedge clk) rb.clr |=> s == '0)
        else $error("Bank not cleared");
endmodule // asq_result_bank

/* dv/tb_core_model.sv */
// Purpose: Behavioural analog core answering the sequencer's start strobes.
// Assumes: One conversion outstanding; result is base XOR channel.
// Notes: Short latencies stand in for the real state counts.
`timescale 1ns/1ps
module tb_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic core_start,
    input wire logic [2:0] core_chan,
    input wire logic core_speed,
    input wire logic [9:0] base,
    output logic core_done,
    output logic [9:0] core_result,
    output int starts
);
    logic [9:0] val;
    int cnt;
    // Result lines carry junk outside the done cycle
    assign core_result = core_done ? val : ~val;
    always @(posedge clk) begin
        core_done <= 1'b0;
        if (rst) begin
            cnt <= 0;
            starts <= 0;
            val <= 10'h000;
        end else if (core_start) begin
            cnt <= core_speed ? 4 : 9;
            starts <= starts + 1;
            val <= base ^ {7'h00, core_chan};
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            core_done <= (cnt == 1);
        end
    end
endmodule // tb_core_model

/* dv/tb_top.sv */
// Purpose: Self-checking bench of the converter sequencer.
// Assumes: Inputs change on the falling edge; read data checked a cycle later.
// Notes: Core latency is shortened in the partner model.
`timescale 1ns/1ps
module tb_top import asq_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic standby = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic bus_rd = 1'b0;
    logic bus_wr = 1'b0;
    logic bus_dma = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic ext_trigger_pin = 1'b1;
    logic [9:0] base = 10'h000;
    logic [15:0] bus_rdata;
    logic conv_end_irq, core_start, core_speed, core_done;
    logic [2:0] core_chan;
    logic [9:0] core_result;
    logic taken = 1'b0;
    logic [15:0] expq[$];
    int starts, s, mismatches = 0, tests_run = 0;

    asq_top dut (.clk(clk), .rst(rst), .standby(standby), .bus_addr(bus_addr),
        .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_dma(bus_dma), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .ext_trigger_pin(ext_trigger_pin),
        .conv_end_irq(conv_end_irq), .core_start(core_start), .core_chan(core_chan),
        .core_speed(core_speed), .core_done(core_done), .core_result(core_result));
    tb_core_model core (.clk(clk), .rst(rst), .core_start(core_start),
        .core_chan(core_chan), .core_speed(core_speed), .base(base),
        .core_done(core_done), .core_result(core_result), .starts(starts));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Read answer stands half a cycle after the taking edge
    always @(posedge clk) taken <= bus_rd;
    always @(negedge clk) begin
        if (taken) begin
            check(bus_rdata, expq.pop_front());
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic dma = 1'b0);
        @(negedge clk);
        bus_addr = a;
        bus_rd = 1'b1;
        bus_dma = dma;
        expq.push_back({e, 8'h00});
        @(negedge clk);
        bus_rd = 1'b0;
        bus_dma = 1'b0;
    endtask

    task automatic rd_res(input logic [1:0] r, input logic [9:0] v);
        rd(OFF_RES_A + {4'h0, r, 2'b00}, v[9:2]);
        rd(OFF_RES_A + {4'h0, r, 2'b10}, {v[1:0], 6'h00});
    endtask

    task automatic wait_irq();
        int n = 0;
        while (conv_end_irq !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check({15'h0, conv_end_irq}, 16'h0001);
    endtask

    task automatic pulse_pin();
        @(negedge clk);
        ext_trigger_pin = 1'b0;
        repeat (12) @(negedge clk);
        ext_trigger_pin = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    initial begin
        #1000000;
        mismatches++;
        close_out();
    end

    initial begin
        logic [7:0] c;
        int n;
        void'($urandom(60170));
        repeat (10) @(negedge clk);
        rst = 1'b0;
        rd(OFF_CSR, CSR_RESET);
        rd(OFF_TCR, TCR_RESET);
        rd(OFF_RES_A, 8'h00);
        wr(OFF_TCR, 8'h00);
        rd(OFF_TCR, 8'h07);
        wr(OFF_TCR, 8'hff);
        rd(OFF_TCR, 8'he7);
        for (int ch = 0; ch < 8; ch++) begin
            // Upper channels run with the scan bit set: single must still stop
            wr(OFF_TCR, ch > 3 ? 8'h20 : 8'h00);
            c = 8'(ch) | (ch[0] ? 8'h08 : 8'h00);
            base = 10'($urandom);
            wr(OFF_CSR, 8'h60 | c);
            wait_irq();
            check(16'(core_chan), 16'(ch));
            check(16'(core_speed), 16'(ch & 1));
            rd(OFF_CSR, 8'hc0 | c);
            wr(OFF_CSR, 8'h40 | c);
            rd(OFF_CSR, 8'h40 | c);
            check(16'(conv_end_irq), 16'h0);
            rd_res(2'(ch), base ^ 10'(ch));
        end
        wr(OFF_TCR, 8'h00);
        base = 10'($urandom);
        wr(OFF_CSR, 8'h60);
        wait_irq();
        rd(OFF_CSR, 8'hc0);
        wr(OFF_CSR, 8'h80);
        rd(OFF_CSR, 8'h80);
        check(16'(conv_end_irq), 16'h0);
        // Any control/status write drops the pending clear
        wr(OFF_CSR, 8'h80);
        wr(OFF_CSR, 8'h00);
        rd(OFF_CSR, 8'h80);
        rd(OFF_RES_A, base[9:2], 1'b1);
        rd(OFF_CSR, 8'h00);
        base = 10'($urandom);
        s = starts;
        wr(OFF_CSR, 8'h76);
        wait_irq();
        check(16'(starts - s), 16'h0003);
        rd(OFF_CSR, 8'hd6);
        for (int k = 0; k < 3; k++) rd_res(2'(k), base ^ 10'(k + 4));
        wr(OFF_CSR, 8'h16);
        wr(OFF_TCR, 8'h20);
        s = starts;
        wr(OFF_CSR, 8'h31);
        n = 0;
        while (starts - s < 5 && n < 500) begin
            @(negedge clk);
            n++;
        end
        rd(OFF_CSR, 8'hb1);
        wr(OFF_CSR, 8'h11);
        s = starts;
        repeat (40) @(negedge clk);
        check(16'(starts - s), 16'h0);
        rd(OFF_CSR, 8'h11);
        wr(OFF_CSR, 8'h02);
        for (int e = 0; e < 3; e++) begin
            wr(OFF_TCR, 8'(e << 6));
            pulse_pin();
            check(16'(starts - s), 16'h0);
        end
        wr(OFF_TCR, 8'hc0);
        pulse_pin();
        check(16'(starts - s), 16'h0001);
        check(16'(core_chan), 16'h0002);
        @(negedge clk);
        standby = 1'b1;
        @(negedge clk);
        standby = 1'b0;
        rd(OFF_CSR, 8'h00);
        rd(OFF_TCR, 8'h07);
        rd_res(2'h1, 10'h000);
        @(negedge clk);
        close_out();
    end
endmodule // tb_top
